// [common/dtf_pkg.sv]
// Package with shared types and constants for the device transport frame state machines.
package dtf_pkg;

	// Frame types reported by the link layer at start of frame.
	localparam logic [7:0] DTF_TYPE_REG_H2D = 8'h27;
	localparam logic [7:0] DTF_TYPE_DATA    = 8'h46;
	localparam logic [7:0] DTF_TYPE_DMA_SETUP = 8'h41;
	localparam logic [7:0] DTF_TYPE_SELFTEST  = 8'h58;

	// Loopback form bit positions inside the self-test pattern byte.
	localparam int DTF_LB_FAR_BIT  = 7;
	localparam int DTF_LB_RETI_BIT = 4;

	// Register frame and setup frame payload widths in dwords.
	localparam int DTF_REG_DWORDS   = 5;
	localparam int DTF_SETUP_DWORDS = 7;
	localparam int DTF_BIST_DWORDS  = 3;

	// Cycles spent in the data prepare state after its first cycle, before receiving.
	localparam logic [1:0] DTF_PREP_CYCLES = 2'h1;

	typedef enum {
		transport_idle_state,
		selftest_tx_build_state,
		selftest_tx_status_state,
		register_frame_rx_state,
		data_rx_prepare_state,
		data_rx_active_state,
		data_rx_abort_state,
		dma_setup_rx_state,
		selftest_rx_check_state,
		loopback_setup_state
	} dtf_state_t;

	// Incoming dword stream from the link layer.
	typedef struct packed {
		logic        sof;
		logic        valid;
		logic        eof;
		logic        crc_err;
		logic [31:0] data;
	} dtf_rx_t;

	// Outgoing dword stream toward the link layer.
	typedef struct packed {
		logic        valid;
		logic        last;
		logic [31:0] data;
	} dtf_tx_t;

endpackage : dtf_pkg

// [rtl/dtf_capture.sv]
// Word capture buffer that holds one received frame payload.
`timescale 1ns/1ns
module dtf_capture
	import dtf_pkg::*;
#(
	parameter int DEPTH = 7
) (
	// Clock and reset.
	input  wire logic              clock,
	input  wire logic              rst,
	// Capture control.
	input  wire logic              clear,
	input  wire logic              push,
	input  wire logic [31:0]       word,
	// Captured words, flattened, word 0 in the low bits.
	output logic [DEPTH*32-1:0]    words,
	output logic [3:0]             count
);

	logic [31:0] mem_reg [DEPTH];
	logic [3:0]  count_reg;
	logic [3:0]  count_next;
	wire         room = count_reg < 4'(DEPTH);

	// Extra words beyond depth are dropped so a long frame cannot overrun.
	assign count_next = clear ? 4'h0 : (push && room) ? count_reg + 4'h1 : count_reg;

	always_ff @(posedge clock) begin
		if (rst) begin
			count_reg <= 4'h0;
		end else begin
			count_reg <= count_next;
		end
	end

	always_ff @(posedge clock) begin
		if (push && room && !clear) begin
			mem_reg[count_reg[2:0]] <= word;
		end
	end

	// Flatten for the consumer; data comes from flip-flops.
	always_comb begin
		for (int i = 0; i < DEPTH; i++) begin
			words[i*32 +: 32] = mem_reg[i];
		end
	end

	assign count = count_reg;

endmodule : dtf_capture

// [rtl/dtf_transport.sv]
// Device transport frame state machines: self-test transmit and four decompose paths.
`timescale 1ns/1ns
// What this block does
// - After the whole self-test frame is handed over, mark it last and await status.
// - In status state, error-free finish returns to idle.
// - In status state, finish with errors resends the self-test frame.
// - Application switches layers to test mode after successful self-test send.
// - Register frame contents reach device registers only if error free.
// - Good register frame notifies the application then returns to idle.
// - Errored register or setup frame reports status to link, no application notice.
// - Illegal transition notice from link forces idle from any state.
// - Data frame first prepares, then enters the data receive state.
// - Data receive waits for end of frame, then returns to idle.
// - Application abort request moves data receive into the abort state.
// - Abort state asks link to send the abort primitive, then resumes receiving.
// - Abort coinciding with end of frame goes straight to idle.
// - Abort mechanism is discouraged yet stays implemented.
// - Good setup frame passes contents to application, notifies, returns to idle.
// - Self-test frame loopback form is checked before acting.
// - Good frame with supported loopback enters loopback setup.
// - Good frame with unsupported loopback returns to idle.
// - Self-test frame with reception error is not acted on; its form still reaches app_loopback_form.
// - Loopback setup notifies application to loop data, then returns to idle.
// - In idle, incoming frame type selects the decompose machine.
module dtf_transport
	import dtf_pkg::*;
#(
	parameter logic [7:0] LB_SUPPORTED = 8'h90
) (
	// Clock and reset.
	input  wire logic        clock,
	input  wire logic        rst,
	// Link layer receive stream and events.
	input  wire dtf_rx_t     rx,
	input  wire logic        link_illegal,
	input  wire logic        tx_done,
	input  wire logic        tx_err,
	// Link layer transmit stream and requests.
	output dtf_tx_t          tx,
	input  wire logic        tx_ready,
	output logic             link_status_err,
	output logic             link_send_abort,
	// Application self-test send request and payload.
	input  wire logic        app_selftest_req,
	input  wire logic [95:0] app_selftest_frame,
	output logic             app_selftest_sent,
	// Application receive side.
	input  wire logic        app_abort_req,
	output logic             data_rx_ready,
	output logic             app_cmd_notify,
	output logic [159:0]     dev_regs,
	output logic             app_setup_notify,
	output logic [223:0]     app_setup_info,
	output logic             app_loopback_notify,
	output logic [7:0]       app_loopback_form,
	// Current state for observation.
	output dtf_state_t       state
);

	dtf_state_t state_reg;
	dtf_state_t state_next;
	logic [1:0] idx_reg;
	logic [1:0] idx_next;
	logic [1:0] prep_reg;
	logic       err_reg;
	logic [159:0] regs_reg;
	logic [223:0] setup_reg;
	logic [7:0] form_reg;
	logic       cmd_n_reg, setup_n_reg, lb_n_reg, sent_reg, stat_reg, abort_reg;
	logic [223:0] cap_words;

	// Frame ended with a CRC error on its last word or earlier.
	wire frame_end   = rx.valid && rx.eof;
	wire frame_bad   = err_reg || rx.crc_err;
	wire is_type     = rx.sof && rx.valid;
	wire [7:0] ftype = rx.data[7:0];
	wire tx_last     = idx_reg == 2'(DTF_BIST_DWORDS - 1);
	wire tx_fire     = tx_ready && (state_reg == selftest_tx_build_state);
	wire [7:0] rx_form = cap_words[39:32];
	// A form is supported only if every requested bit is in the supported set.
	wire form_ok     = (rx_form & ~LB_SUPPORTED) == 8'h00 && rx_form != 8'h00;
	wire cap_clear   = state_reg == transport_idle_state;
	wire cap_push    = rx.valid && state_reg inside {register_frame_rx_state, dma_setup_rx_state,
		selftest_rx_check_state} || is_type && cap_clear;

	dtf_capture #(.DEPTH(DTF_SETUP_DWORDS)) u_cap (
		.clock (clock),
		.rst   (rst),
		.clear (cap_clear && !is_type),
		.push  (cap_push),
		.word  (rx.data),
		.words (cap_words),
		.count ()
	);

	// Next state selection.
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			transport_idle_state: begin
				if (app_selftest_req) state_next = selftest_tx_build_state;
				else if (is_type) begin
					case (ftype)
						DTF_TYPE_REG_H2D:  state_next = register_frame_rx_state;
						DTF_TYPE_DATA:     state_next = data_rx_prepare_state;
						DTF_TYPE_DMA_SETUP: state_next = dma_setup_rx_state;
						DTF_TYPE_SELFTEST: state_next = selftest_rx_check_state;
						default:           state_next = transport_idle_state;
					endcase
				end
			end
			selftest_tx_build_state:
				if (tx_fire && tx_last) state_next = selftest_tx_status_state;
			selftest_tx_status_state:
				if (tx_done) state_next = tx_err ? selftest_tx_build_state : transport_idle_state;
			register_frame_rx_state, dma_setup_rx_state:
				if (frame_end) state_next = transport_idle_state;
			data_rx_prepare_state:
				if (prep_reg == DTF_PREP_CYCLES) state_next = data_rx_active_state;
			data_rx_active_state: begin
				if (frame_end) state_next = transport_idle_state;
				else if (app_abort_req) state_next = data_rx_abort_state;
			end
			data_rx_abort_state:
				state_next = frame_end ? transport_idle_state : data_rx_active_state;
			selftest_rx_check_state:
				if (frame_end) state_next = (!frame_bad && form_ok) ? loopback_setup_state
					: transport_idle_state;
			loopback_setup_state:
				state_next = transport_idle_state;
			default: state_next = transport_idle_state;
		endcase
		if (link_illegal) state_next = transport_idle_state;
	end

	// Index wraps on the last word so it never points past the three payload words.
	assign idx_next = (state_reg != selftest_tx_build_state || (tx_fire && tx_last)) ? 2'h0
		: tx_fire ? idx_reg + 2'h1 : idx_reg;

	always_ff @(posedge clock) begin
		if (rst) begin
			state_reg <= transport_idle_state;
			idx_reg   <= 2'h0;
			prep_reg  <= 2'h0;
			err_reg   <= 1'b0;
		end else begin
			state_reg <= state_next;
			idx_reg   <= idx_next;
			prep_reg  <= (state_reg == data_rx_prepare_state) ? prep_reg + 2'h1 : 2'h0;
			// The idle clear yields to a start word, so a fault on the type dword is kept.
			err_reg   <= (cap_clear && !is_type) ? 1'b0 : err_reg | (rx.valid && rx.crc_err);
		end
	end

	// Notices and payload registers; payload written only on clean frames, except the loopback form, written at every self-test frame end.
	always_ff @(posedge clock) begin
		if (rst) begin
			regs_reg    <= '0;
			setup_reg   <= '0;
			form_reg    <= 8'h00;
			cmd_n_reg   <= 1'b0;
			setup_n_reg <= 1'b0;
			lb_n_reg    <= 1'b0;
			sent_reg    <= 1'b0;
			stat_reg    <= 1'b0;
			abort_reg   <= 1'b0;
		end else begin
			cmd_n_reg   <= 1'b0;
			setup_n_reg <= 1'b0;
			lb_n_reg    <= 1'b0;
			sent_reg    <= state_reg == selftest_tx_status_state && tx_done && !tx_err && !link_illegal;
			stat_reg    <= frame_end && frame_bad && !link_illegal &&
				state_reg inside {register_frame_rx_state, dma_setup_rx_state};
			abort_reg   <= state_reg == data_rx_abort_state;
			if (state_reg == register_frame_rx_state && frame_end && !frame_bad && !link_illegal) begin
				regs_reg  <= {rx.data, cap_words[127:0]};
				cmd_n_reg <= 1'b1;
			end
			if (state_reg == dma_setup_rx_state && frame_end && !frame_bad && !link_illegal) begin
				setup_reg   <= {rx.data, cap_words[191:0]};
				setup_n_reg <= 1'b1;
			end
			if (state_reg == selftest_rx_check_state && frame_end) form_reg <= rx_form;
			if (state_reg == loopback_setup_state) lb_n_reg <= 1'b1;
		end
	end

	// Transmit stream is a handshake output; the word comes from the held payload.
	assign tx.valid = state_reg == selftest_tx_build_state;
	assign tx.last  = tx_last;
	assign tx.data  = app_selftest_frame[idx_reg*32 +: 32];

	assign data_rx_ready       = state_reg inside {data_rx_active_state, data_rx_abort_state};
	assign link_status_err     = stat_reg;
	assign link_send_abort     = abort_reg;
	assign app_cmd_notify      = cmd_n_reg;
	assign dev_regs            = regs_reg;
	assign app_setup_notify    = setup_n_reg;
	assign app_setup_info      = setup_reg;
	assign app_loopback_notify = lb_n_reg;
	assign app_loopback_form   = form_reg;
	assign app_selftest_sent   = sent_reg;
	assign state               = state_reg;

	// Checks.
	property p_tx_retry;
		@(posedge clock) disable iff (rst)
		state_reg == selftest_tx_status_state && tx_done && tx_err && !link_illegal |=> state_reg == selftest_tx_build_state;
	endproperty
	a_tx_retry: assert property (p_tx_retry) else $error("self-test frame not resent after error");

	property p_tx_ok;
		@(posedge clock) disable iff (rst)
		state_reg == selftest_tx_status_state && tx_done && !tx_err && !link_illegal
			|=> state_reg == transport_idle_state ##0 app_selftest_sent;
	endproperty
	a_tx_ok: assert property (p_tx_ok) else $error("good self-test send did not reach idle");

	property p_illegal;
		@(posedge clock) disable iff (rst) link_illegal |=> state_reg == transport_idle_state;
	endproperty
	a_illegal: assert property (p_illegal) else $error("illegal notice did not force idle");

	property p_reg_bad;
		@(posedge clock) disable iff (rst)
		state_reg == register_frame_rx_state && frame_end && frame_bad && !link_illegal
			|=> !app_cmd_notify && link_status_err && $stable(dev_regs);
	endproperty
	a_reg_bad: assert property (p_reg_bad) else $error("bad register frame was accepted");

	property p_reg_ok;
		@(posedge clock) disable iff (rst)
		state_reg == register_frame_rx_state && frame_end && !frame_bad && !link_illegal
			|=> app_cmd_notify && state_reg == transport_idle_state;
	endproperty
	a_reg_ok: assert property (p_reg_ok) else $error("good register frame not notified");

	property p_abort;
		@(posedge clock) disable iff (rst)
		state_reg == data_rx_abort_state && !link_illegal
			|=> link_send_abort && state_reg == ($past(frame_end) ? transport_idle_state : data_rx_active_state);
	endproperty
	a_abort: assert property (p_abort) else $error("abort state exit wrong");

	property p_prep;
		@(posedge clock) disable iff (rst)
		$rose(state_reg == data_rx_prepare_state) && !link_illegal ##1 !link_illegal
			|=> state_reg == data_rx_active_state;
	endproperty
	a_prep: assert property (p_prep) else $error("data prepare did not enter receive");

	property p_loop;
		@(posedge clock) disable iff (rst)
		state_reg == loopback_setup_state |=> app_loopback_notify && state_reg == transport_idle_state;
	endproperty
	a_loop: assert property (p_loop) else $error("loopback setup did not notify");

	property p_setup_bad;
		@(posedge clock) disable iff (rst)
		state_reg == dma_setup_rx_state && frame_end && frame_bad |=> !app_setup_notify;
	endproperty
	a_setup_bad: assert property (p_setup_bad) else $error("bad setup frame notified");

endmodule : dtf_transport

// [testbench/dtf_link_model.sv]
// Link layer stand-in that takes self-test words and reports their send status.
`timescale 1ns/1ns
module dtf_link_model
	import dtf_pkg::*;
(
	// Clock and reset.
	input  wire logic        clock,
	input  wire logic        rst,
	// Transmit stream and status.
	input  wire dtf_tx_t     tx,
	output logic             tx_ready,
	output logic             tx_done,
	output logic             tx_err,
	// Bench controls and observations.
	input  wire logic        inject_err,
	input  wire logic        slow,
	output logic [95:0]      got_frame,
	output logic [1:0]       last_idx,
	output logic [3:0]       n_frames
);
	logic [1:0] idx_reg;
	logic [1:0] wait_reg;
	logic       ready_reg;

	// Stalling on alternate cycles forces the sender to hold each word.
	assign tx_ready = slow ? ready_reg : 1'b1;

	// Status comes three cycles after the last word; tx_err wanders outside the pulse.
	always_ff @(posedge clock) begin
		if (rst) begin
			idx_reg   <= 2'h0;
			wait_reg  <= 2'h0;
			ready_reg <= 1'b0;
			tx_done   <= 1'b0;
			tx_err    <= 1'b0;
			got_frame <= '0;
			last_idx  <= 2'h0;
			n_frames  <= 4'h0;
		end else begin
			ready_reg <= ~ready_reg;
			tx_done   <= (wait_reg == 2'h1);
			tx_err    <= (wait_reg == 2'h1) ? inject_err : ~tx_err;
			if (wait_reg != 2'h0)
				wait_reg <= wait_reg - 2'h1;
			if (tx.valid && tx_ready) begin
				got_frame[idx_reg*32 +: 32] <= tx.data;
				idx_reg                     <= idx_reg + 2'h1;
				if (tx.last) begin
					last_idx <= idx_reg;
					idx_reg  <= 2'h0;
					wait_reg <= 2'h3;
					n_frames <= n_frames + 4'h1;
				end
			end
		end
	end
endmodule : dtf_link_model

// [testbench/dtf_transport_tb.sv]
// Self-checking bench for the device transport frame state machines.
`timescale 1ns/1ns
`define CHK(nm, e, g) begin \
	total_checks++; \
	if ((g) !== (e)) begin \
		n_fail++; \
		$display("CHECK FAILED %s expected %0h seen %0h", nm, e, g); \
	end \
end
module dtf_transport_tb
	import dtf_pkg::*;
;
	localparam logic [7:0] LB_MASK = 8'h90;
	logic clock = 1'b0;
	logic rst = 1'b1;
	dtf_rx_t rx;
	dtf_tx_t tx;
	dtf_state_t state;
	logic link_illegal, tx_done, tx_err, tx_ready, link_status_err, link_send_abort;
	logic app_selftest_req, app_selftest_sent, app_abort_req, data_rx_ready, inject_err, slow;
	logic app_cmd_notify, app_setup_notify, app_loopback_notify;
	logic [95:0] app_selftest_frame, got_frame;
	logic [159:0] dev_regs, exp_regs;
	logic [223:0] app_setup_info, exp_setup;
	logic [7:0] app_loopback_form;
	logic [1:0] last_idx;
	logic [3:0] n_frames;
	logic [5:0] pv;
	int n_fail = 0;
	int total_checks = 0;
	int cycles = 0;
	int cnt[6] = '{default: 0};
	int base[6];
	integer seed = 32'h98712737;
	logic [31:0] r;
	logic [7:0] forms[5] = '{8'h80, 8'h10, 8'h90, 8'h02, 8'h00};

	dtf_transport dtf_transport_i (.clock(clock), .rst(rst), .rx(rx), .link_illegal(link_illegal),
		.tx_done(tx_done), .tx_err(tx_err), .tx(tx), .tx_ready(tx_ready), .link_status_err(link_status_err),
		.link_send_abort(link_send_abort), .app_selftest_req(app_selftest_req),
		.app_selftest_frame(app_selftest_frame), .app_selftest_sent(app_selftest_sent),
		.app_abort_req(app_abort_req), .data_rx_ready(data_rx_ready), .app_cmd_notify(app_cmd_notify),
		.dev_regs(dev_regs), .app_setup_notify(app_setup_notify), .app_setup_info(app_setup_info),
		.app_loopback_notify(app_loopback_notify), .app_loopback_form(app_loopback_form), .state(state));
	dtf_link_model dtf_link_model_i (.clock(clock), .rst(rst), .tx(tx), .tx_ready(tx_ready), .tx_done(tx_done),
		.tx_err(tx_err), .inject_err(inject_err), .slow(slow), .got_frame(got_frame), .last_idx(last_idx),
		.n_frames(n_frames));

	// Clock at 50 MHz.
	always #10 clock = ~clock;

	// Pulses are counted at every rising edge so a scenario only compares the growth.
	assign pv = {app_selftest_sent, link_send_abort, link_status_err, app_loopback_notify, app_setup_notify,
		app_cmd_notify};
	always @(posedge clock) begin
		cycles++;
		for (int i = 0; i < 6; i++)
			cnt[i] += (pv[i] === 1'b1);
		if (cycles == 5000) begin
			n_fail++;
			results();
		end
	end

	// A released receive line shows a changing pattern rather than the last word.
	task automatic idle_rx;
		rx <= {4'h0, $random(seed)};
	endtask : idle_rx

	function automatic logic lb_ok(input logic [7:0] f);
		return (f != 8'h00) && ((f & ~LB_MASK) == 8'h00);
	endfunction : lb_ok

	task automatic chk_cnt(input string nm, input int i, input int e);
		`CHK(nm, e, cnt[i] - base[i])
	endtask : chk_cnt

	// Sends a whole frame, one dword per cycle, with an optional checksum fault.
	task automatic frame(input logic [7:0] ty, input int err_at, input logic [7:0] form);
		logic [223:0] w;
		logic [31:0] d;
		int n;
		logic good;
		n = (ty == DTF_TYPE_REG_H2D) ? DTF_REG_DWORDS : (ty == DTF_TYPE_DMA_SETUP) ? DTF_SETUP_DWORDS : DTF_BIST_DWORDS;
		good = (err_at < 0);
		w = '0;
		base = cnt;
		for (int k = 0; k < n; k++) begin
			d = $random(seed);
			if (k == 0) d[7:0] = ty;
			if (k == 1) d[7:0] = form;
			w[k*32 +: 32] = d;
			@(posedge clock);
			rx <= {k == 0, 1'b1, k == n - 1, k == err_at, d};
		end
		@(posedge clock);
		idle_rx();
		repeat (4) @(posedge clock);
		if (ty == DTF_TYPE_REG_H2D) begin
			if (good) exp_regs = w[159:0];
			`CHK("dev_regs", exp_regs, dev_regs)
			chk_cnt("cmd_notify", 0, good);
			chk_cnt("status_err", 3, !good);
		end else if (ty == DTF_TYPE_DMA_SETUP) begin
			if (good) exp_setup = w;
			`CHK("setup_info", exp_setup, app_setup_info)
			chk_cnt("setup_notify", 1, good);
			chk_cnt("status_err", 3, !good);
		end else begin
			chk_cnt("loop_notify", 2, ty == DTF_TYPE_SELFTEST && good && lb_ok(form));
			if (ty == DTF_TYPE_SELFTEST && good && lb_ok(form))
				`CHK("loop_form", form, app_loopback_form)
		end
		`CHK("idle", transport_idle_state, state)
		$display("frame type %0h error at %0d done", ty, err_at);
	endtask : frame

	// Data frame with an abort, either alone or together with the end of frame.
	task automatic data_frame(input logic coincide);
		logic [31:0] d;
		int k;
		base = cnt;
		d = $random(seed);
		d[7:0] = DTF_TYPE_DATA;
		@(posedge clock);
		rx <= {4'b1100, d};
		@(posedge clock);
		idle_rx();
		@(posedge clock);
		`CHK("prepare", data_rx_prepare_state, state)
		k = 0;
		while (state !== data_rx_active_state && k < 5) begin
			@(posedge clock);
			k++;
		end
		`CHK("active", data_rx_active_state, state)
		`CHK("rx_ready", 1'b1, data_rx_ready)
		app_abort_req <= 1'b1;
		@(posedge clock);
		app_abort_req <= 1'b0;
		if (coincide) rx <= {4'b0110, d};
		@(posedge clock);
		idle_rx();
		`CHK("abort", data_rx_abort_state, state)
		repeat (2) @(posedge clock);
		chk_cnt("send_abort", 4, 1);
		`CHK("after_abort", coincide ? transport_idle_state : data_rx_active_state, state)
		if (!coincide) begin
			@(posedge clock);
			rx <= {4'b0110, d};
			@(posedge clock);
			idle_rx();
			repeat (2) @(posedge clock);
			`CHK("data_end", transport_idle_state, state)
		end
		$display("data frame coincide %0d done", coincide);
	endtask : data_frame

	task automatic results;
		$display("checks %0d mismatches %0d", total_checks, n_fail);
		if (n_fail == 0 && total_checks > 0)
			$display("Test passed");
		else
			$display("Test failed");
		$finish;
	endtask : results

	// Main sequence: corner frames, random frames, data aborts, link fault, self-test send.
	initial begin
		rx = '0;
		{link_illegal, app_selftest_req, app_abort_req, inject_err, slow} = 5'h00;
		app_selftest_frame = '0;
		exp_regs = '0;
		exp_setup = '0;
		repeat (4) @(posedge clock);
		rst <= 1'b0;
		@(posedge clock);
		`CHK("reset_state", transport_idle_state, state)
		frame(DTF_TYPE_REG_H2D, -1, 8'h00);
		frame(DTF_TYPE_REG_H2D, 4, 8'h00);
		frame(DTF_TYPE_DMA_SETUP, -1, 8'h00);
		frame(DTF_TYPE_DMA_SETUP, 0, 8'h00);
		foreach (forms[i])
			frame(DTF_TYPE_SELFTEST, -1, forms[i]);
		frame(DTF_TYPE_SELFTEST, 2, 8'h80);
		frame(8'h39, -1, 8'h80);
		repeat (8) begin
			r = $random(seed);
			frame(r[0] ? DTF_TYPE_REG_H2D : DTF_TYPE_DMA_SETUP, r[1] ? -1 : int'(r[5:3] % 5), 8'h00);
		end
		data_frame(1'b0);
		data_frame(1'b1);
		base = cnt;
		@(posedge clock);
		rx <= {4'b1100, 24'h000000, DTF_TYPE_REG_H2D};
		@(posedge clock);
		rx <= {4'b0100, $random(seed)};
		@(posedge clock);
		link_illegal <= 1'b1;
		idle_rx();
		@(posedge clock);
		link_illegal <= 1'b0;
		@(posedge clock);
		`CHK("illegal_idle", transport_idle_state, state)
		repeat (3) @(posedge clock);
		chk_cnt("illegal_notify", 0, 0);
		$display("link fault done");
		base = cnt;
		slow <= 1'b1;
		inject_err <= 1'b1;
		app_selftest_frame <= {$random(seed), $random(seed), $random(seed)};
		@(posedge clock);
		app_selftest_req <= 1'b1;
		@(posedge clock);
		app_selftest_req <= 1'b0;
		for (int k = 0; k < 40 && tx_done !== 1'b1; k++)
			@(posedge clock);
		inject_err <= 1'b0;
		@(posedge clock);
		`CHK("retry", selftest_tx_build_state, state)
		repeat (30) @(posedge clock);
		chk_cnt("sent", 5, 1);
		`CHK("sent_idle", transport_idle_state, state)
		`CHK("tx_frame", app_selftest_frame, got_frame)
		`CHK("last_word", 2'h2, last_idx)
		`CHK("frames", 4'h2, n_frames)
		$display("self-test send done");
		results();
	end
endmodule : dtf_transport_tb
